// File: logic/eth_port_cfg.svh
`ifndef ETH_PORT_CFG_SVH
`define ETH_PORT_CFG_SVH
// Summary of operation
// - Without automatic flow control, host bits request a pause frame or jamming.
// - Reduced-pin mode moves two-bit symbols timed by a 50 MHz reference.
// - Full media-independent mode moves four-bit symbols at a 25 MHz reference.
// - A dedicated pin, not a register, picks reduced-pin or full mode.
// - As DCE in full mode, transmit and receive clocks derive from reference.
// - Maximum receive frame size comes from a high and low register pair.
// - The limit in bits is the programmed value multiplied by eight.
// - Counted length runs from destination address to CRC, no preamble or SFD.
// - Frames longer than the programmed maximum are rejected, both directions.
// - Frame status registers update per frame and hold only the latest.
// - Each transmit error kind sets its own transmit status bit.
// - A frame with a transmit error is resent when its enable bit is set.
// - Deferral and heartbeat failure each have their own resend bit.
// - No carrier flushes the transmit queue when the flush bit is set.
// - Per-error accept bits decide receive rejection; reset value rejects all.
// - Runt and collided frames are always rejected.
// - Without a host, all errored frames are rejected or resent.
// - A dedicated pin picks DTE or DCE operation.
// - Indirect write: load data and address, direction 0, status 1; clears.
// - Indirect read: load address, direction 1; data valid once status clears.
`define EP_OFF_WDATA0 5'h00
`define EP_OFF_WADDR_LO 5'h04
`define EP_OFF_WADDR_HI 5'h05
`define EP_OFF_CTRL 5'h06
`define EP_OFF_RADDR_LO 5'h07
`define EP_OFF_RADDR_HI 5'h08
`define EP_OFF_RDATA0 5'h09
`define EP_OFF_MAX_HI 5'h0d
`define EP_OFF_MAX_LO 5'h0e
`define EP_OFF_TFRC_LO 5'h0f
`define EP_OFF_TFRC_HI 5'h10
`define EP_OFF_RFRC 5'h11
`define EP_OFF_JAM 5'h12
`define EP_OFF_TFS_LO 5'h13
`define EP_OFF_TFS_HI 5'h14
`define EP_OFF_RFS 5'h15
`define EP_OFF_MODE 5'h16
`define EP_MAC_CTRL 16'h0000
`define EP_MAC_AH 16'h0004
`define EP_MAC_AL 16'h0008
`define EP_MAC_MIIA 16'h0014
`define EP_MAC_MIID 16'h0018
`define EP_MAC_FCR 16'h001c
`define EP_MAC_MMC 16'h0100
`define EP_MC_SPD100 14
`define EP_MC_FDX 20
`define EP_CTL_DIR 1
`define EP_CTL_CS 0
`define EP_TE_NOCAR 1
`define EP_TFRC_FLUSH 9
`define EP_MAX_RST 16'h05ee
`define EP_IND_CYC 3'd3
`define EP_RUNT_LEN 11'd64
`define EP_SFD 8'hd5
`define EP_CTL_TYPE 16'h8808
`define EP_PAUSE_OP 16'h0001
`define EP_LEN_TYPE 16'h0600
`define EP_HDR_LEN 11'd18
`define EP_CRC_RES 32'hdebb20e3
`define EP_REF_KHZ 25000
`define EP_CLK10_KHZ 2500
`define EP_DIV10_HALF (`EP_REF_KHZ / `EP_CLK10_KHZ / 2)
`endif

// File: logic/eth_port_pkg.sv
package eth_port_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_PRE = 2'b01,
        RX_DATA = 2'b11
    } rx_state_t;
endpackage

// File: logic/ethernet_port_mac_control.sv
`timescale 1ns/1ps
`include "eth_port_cfg.svh"
module ethernet_port_mac_control #(
    parameter int LEN_W = 11
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [4:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire eth_port_pkg::byte_t host_wdata,
    output eth_port_pkg::byte_t host_rdata,
    input wire logic hw_mode,
    input wire logic auto_flow,
    input wire logic reduced_pin_select,
    input wire logic port_role_select,
    input wire logic link_clk,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [3:0] rxd,
    input wire logic col,
    output logic dce_clk_out,
    output logic dce_clk_oe_n,
    input wire logic tx_done,
    input wire logic [8:0] tx_err,
    input wire logic [LEN_W-1:0] tx_len,
    output logic tx_retry,
    output logic tx_drop,
    output logic tx_queue_flush,
    output logic rx_accept,
    output logic rx_reject,
    input wire logic pause_done,
    output logic pause_req,
    output logic jam_req
);
    import eth_port_pkg::*;

    localparam int IND_MAX = 3;

    // Length check shared by both directions; bits are the byte count times 8.
    function automatic logic over_max(input logic [LEN_W-1:0] len,
                                      input logic [15:0] max);
        over_max = {5'h00, len, 3'h0} > {max, 3'h0};
    endfunction

    // Indirect address to slot of the MAC register array; 7 means unmapped.
    function automatic logic [2:0] mac_idx(input logic [15:0] a);
        unique case (a)
            `EP_MAC_CTRL: mac_idx = 3'h0;
            `EP_MAC_AH: mac_idx = 3'h1;
            `EP_MAC_AL: mac_idx = 3'h2;
            `EP_MAC_MIIA: mac_idx = 3'h3;
            `EP_MAC_MIID: mac_idx = 3'h4;
            `EP_MAC_FCR: mac_idx = 3'h5;
            `EP_MAC_MMC: mac_idx = 3'h6;
            default: mac_idx = 3'h7;
        endcase
    endfunction

    // CRC32 over one byte, least significant bit first.
    function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                             input byte_t b);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
        end
        crc_byte = r;
    endfunction

    // The three mode pins pass two flops before anything reads them; auto_flow goes straight to the flow-request flops.
    logic [1:0] hw_s_ff, rp_s_ff, role_s_ff;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hw_s_ff <= 2'h0;
            rp_s_ff <= 2'h0;
            role_s_ff <= 2'h0;
        end else begin
            hw_s_ff <= {hw_s_ff[0], hw_mode};
            rp_s_ff <= {rp_s_ff[0], reduced_pin_select};
            role_s_ff <= {role_s_ff[0], port_role_select};
        end
    end
    wire no_host = hw_s_ff[1];

    // Direct host registers.
    logic [31:0] wdata_ff, rdata_ff;
    logic [15:0] waddr_ff, raddr_ff, max_ff;
    logic [9:0] tfrc_ff;
    logic [5:0] rfrc_ff;
    logic jam_en_ff, cs_ff, dir_ff;
    logic [2:0] ind_cnt_ff;
    logic [31:0] mac_reg_ff [7];
    logic [15:0] tfs_ff;
    byte_t rfs_ff;

    wire wr_ctrl = host_wr && host_addr == `EP_OFF_CTRL;
    wire start_wr = wr_ctrl && !cs_ff && !host_wdata[`EP_CTL_DIR] &&
                    host_wdata[`EP_CTL_CS];
    wire start_rd = wr_ctrl && !cs_ff && host_wdata[`EP_CTL_DIR];
    wire ind_fin = cs_ff && ind_cnt_ff == 3'h1;
    wire [2:0] w_idx = mac_idx(waddr_ff);
    wire [2:0] r_idx = mac_idx(raddr_ff);
    wire [31:0] mac_ctrl = mac_reg_ff[0];
    wire pause_busy = mac_reg_ff[5][0];

    // Plain register writes; offsets 0 to 3 are the four write-data bytes.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wdata_ff <= 32'h0;
            waddr_ff <= 16'h0;
            raddr_ff <= 16'h0;
            max_ff <= `EP_MAX_RST;
            tfrc_ff <= 10'h0;
            rfrc_ff <= 6'h0;
            jam_en_ff <= 1'b0;
        end else if (host_wr) begin
            unique case (host_addr)
                5'h00, 5'h01, 5'h02, 5'h03:
                    wdata_ff[host_addr[1:0]*8 +: 8] <= host_wdata;
                `EP_OFF_WADDR_LO: waddr_ff[7:0] <= host_wdata;
                `EP_OFF_WADDR_HI: waddr_ff[15:8] <= host_wdata;
                `EP_OFF_RADDR_LO: raddr_ff[7:0] <= host_wdata;
                `EP_OFF_RADDR_HI: raddr_ff[15:8] <= host_wdata;
                `EP_OFF_MAX_HI: max_ff[15:8] <= host_wdata;
                `EP_OFF_MAX_LO: max_ff[7:0] <= host_wdata;
                `EP_OFF_TFRC_LO: tfrc_ff[7:0] <= host_wdata;
                `EP_OFF_TFRC_HI: tfrc_ff[9:8] <= host_wdata[1:0];
                `EP_OFF_RFRC: rfrc_ff <= host_wdata[5:0];
                `EP_OFF_JAM: jam_en_ff <= host_wdata[0];
                default: ;
            endcase
        end
    end

    // Indirect engine: busy holds the status bit until the access lands.
    // Requests while busy are ignored, so the host must poll first.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cs_ff <= 1'b0;
            dir_ff <= 1'b0;
            ind_cnt_ff <= 3'h0;
        end else if (start_wr || start_rd) begin
            cs_ff <= 1'b1;
            dir_ff <= start_rd;
            ind_cnt_ff <= `EP_IND_CYC;
        end else if (cs_ff) begin
            ind_cnt_ff <= ind_cnt_ff - 3'h1;
            cs_ff <= !ind_fin;
        end
    end

    // MAC register array. The transmitter clears the pause bit when the
    // frame is out, but a host write in the same cycle wins.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 7; i++) begin
                mac_reg_ff[i] <= 32'h0;
            end
            rdata_ff <= 32'h0;
        end else begin
            if (pause_done) begin
                mac_reg_ff[5][0] <= 1'b0;
            end
            if (ind_fin && !dir_ff && w_idx != 3'h7) begin
                mac_reg_ff[w_idx] <= wdata_ff;
            end
            if (ind_fin && dir_ff) begin
                rdata_ff <= (r_idx == 3'h7) ? 32'h0 : mac_reg_ff[r_idx];
            end
        end
    end

    // Read selection; unmapped offsets read zero.
    byte_t rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (host_addr)
            5'h00, 5'h01, 5'h02, 5'h03:
                rd_mux = wdata_ff[host_addr[1:0]*8 +: 8];
            `EP_OFF_WADDR_LO: rd_mux = waddr_ff[7:0];
            `EP_OFF_WADDR_HI: rd_mux = waddr_ff[15:8];
            `EP_OFF_CTRL: rd_mux = {6'h00, dir_ff, cs_ff};
            `EP_OFF_RADDR_LO: rd_mux = raddr_ff[7:0];
            `EP_OFF_RADDR_HI: rd_mux = raddr_ff[15:8];
            5'h09, 5'h0a, 5'h0b, 5'h0c:
                rd_mux = rdata_ff[(host_addr - `EP_OFF_RDATA0)*8 +: 8];
            `EP_OFF_MAX_HI: rd_mux = max_ff[15:8];
            `EP_OFF_MAX_LO: rd_mux = max_ff[7:0];
            `EP_OFF_TFRC_LO: rd_mux = tfrc_ff[7:0];
            `EP_OFF_TFRC_HI: rd_mux = {6'h00, tfrc_ff[9:8]};
            `EP_OFF_RFRC: rd_mux = {2'h0, rfrc_ff};
            `EP_OFF_JAM: rd_mux = {7'h00, jam_en_ff};
            `EP_OFF_TFS_LO: rd_mux = tfs_ff[7:0];
            `EP_OFF_TFS_HI: rd_mux = tfs_ff[15:8];
            `EP_OFF_RFS: rd_mux = rfs_ff;
            `EP_OFF_MODE: rd_mux = {5'h00, no_host, role_s_ff[1], rp_s_ff[1]};
            default: rd_mux = 8'h00;
        endcase
    end

    // Transmit status, resend, flush and oversize drop per finished frame.
    wire [8:0] resend_en = no_host ? 9'h1ff : tfrc_ff[8:0];
    wire tx_big = over_max(tx_len, max_ff);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tfs_ff <= 16'h0;
            tx_retry <= 1'b0;
            tx_drop <= 1'b0;
            tx_queue_flush <= 1'b0;
        end else begin
            if (tx_done) begin
                tfs_ff <= {6'h00, tx_big, tx_err};
            end
            tx_retry <= tx_done && |(tx_err & resend_en);
            tx_drop <= tx_done && tx_big;
            tx_queue_flush <= tx_done && tx_err[`EP_TE_NOCAR] &&
                              tfrc_ff[`EP_TFRC_FLUSH];
        end
    end

    // Host flow control only acts while automatic control is off.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pause_req <= 1'b0;
            jam_req <= 1'b0;
        end else begin
            pause_req <= pause_busy && !auto_flow;
            jam_req <= jam_en_ff && !auto_flow;
        end
    end

    // ---- Link domain: reset release is synchronised to the link clock.
    logic [1:0] lrst_ff, lrp_ff, lspd_ff;
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lrst_ff <= 2'h0;
            lrp_ff <= 2'h0;
            lspd_ff <= 2'h0;
        end else begin
            lrst_ff <= {lrst_ff[0], 1'b1};
            lrp_ff <= {lrp_ff[0], reduced_pin_select};
            lspd_ff <= {lspd_ff[0], mac_ctrl[`EP_MC_SPD100]};
        end
    end
    wire lrst_n = lrst_ff[1];
    wire rmii = lrp_ff[1];

    // DCE clock: 25 MHz passes at 100 Mbps, divide by ten at 10 Mbps.
    // The 100 Mbps path is the reference itself; a flop cannot run that fast.
    logic [2:0] div_ff;
    logic div_clk_ff;
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            div_ff <= 3'h0;
            div_clk_ff <= 1'b0;
        end else if (div_ff == 3'(`EP_DIV10_HALF - 1)) begin
            div_ff <= 3'h0;
            div_clk_ff <= !div_clk_ff;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end
    assign dce_clk_out = lspd_ff[1] ? link_clk : div_clk_ff;
    // Drive the clock pins only as DCE in full mode; held off in reset.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) dce_clk_oe_n <= 1'b1;
        else dce_clk_oe_n <= !(role_s_ff[1] && !rp_s_ff[1]);
    end

    // Receive framing: symbols of four bits, or two in reduced-pin mode.
    rx_state_t rx_st_ff;
    byte_t sr_ff;
    logic [1:0] sym_ff;
    logic [LEN_W-1:0] len_ff, res_len_ff;
    logic [31:0] crc_ff;
    logic [15:0] type_ff, op_ff;
    logic er_ff, col_ff, res_tog_ff;
    logic [6:0] res_fl_ff;
    wire byte_t nxt_sr = rmii ? {rxd[1:0], sr_ff[7:2]}
                              : {rxd, sr_ff[7:4]};
    wire sym_last = sym_ff == (rmii ? 2'h3 : 2'h1);
    wire ctl_fr = type_ff == `EP_CTL_TYPE;
    wire len_bad = type_ff < `EP_LEN_TYPE &&
                   type_ff[LEN_W-1:0] != len_ff - `EP_HDR_LEN;

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            rx_st_ff <= RX_IDLE;
            sr_ff <= 8'h00;
            sym_ff <= 2'h0;
            len_ff <= '0;
            crc_ff <= 32'h0;
            type_ff <= 16'h0;
            op_ff <= 16'h0;
            er_ff <= 1'b0;
            col_ff <= 1'b0;
        end else begin
            unique case (rx_st_ff)
                RX_IDLE: begin
                    sr_ff <= 8'h00;
                    if (rx_dv) rx_st_ff <= RX_PRE;
                end
                RX_PRE: begin
                    sr_ff <= nxt_sr;
                    if (!rx_dv) begin
                        rx_st_ff <= RX_IDLE;
                    end else if (nxt_sr == `EP_SFD) begin
                        rx_st_ff <= RX_DATA;
                        sym_ff <= 2'h0;
                        len_ff <= '0;
                        crc_ff <= 32'hffffffff;
                        er_ff <= 1'b0;
                        col_ff <= 1'b0;
                        type_ff <= 16'h0;
                    end
                end
                RX_DATA: begin
                    if (!rx_dv) begin
                        rx_st_ff <= RX_IDLE;
                    end else begin
                        sr_ff <= nxt_sr;
                        sym_ff <= sym_last ? 2'h0 : sym_ff + 2'h1;
                        er_ff <= er_ff || rx_er;
                        col_ff <= col_ff || col;
                        if (sym_last) begin
                            if (~&len_ff) len_ff <= len_ff + 1'b1;
                            crc_ff <= crc_byte(crc_ff, nxt_sr);
                            if (len_ff == 11'd12) type_ff[15:8] <= nxt_sr;
                            if (len_ff == 11'd13) type_ff[7:0] <= nxt_sr;
                            if (len_ff == 11'd14) op_ff[15:8] <= nxt_sr;
                            if (len_ff == 11'd15) op_ff[7:0] <= nxt_sr;
                        end
                    end
                end
            endcase
        end
    end

    // Frame result is held until the next frame end, far longer than the
    // core needs to see the toggle, so the word crosses unchanged.
    wire rx_end = rx_st_ff == RX_DATA && !rx_dv;
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            res_len_ff <= '0;
            res_fl_ff <= 7'h0;
            res_tog_ff <= 1'b0;
        end else if (rx_end) begin
            res_len_ff <= len_ff;
            res_fl_ff <= {col_ff, ctl_fr && op_ff != `EP_PAUSE_OP, ctl_fr,
                          len_bad, crc_ff != `EP_CRC_RES, sym_ff != 2'h0,
                          er_ff};
            res_tog_ff <= !res_tog_ff;
        end
    end

    // ---- Core side of the crossing and the accept decision.
    logic [2:0] tog_s_ff;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) tog_s_ff <= 3'h0;
        else tog_s_ff <= {tog_s_ff[1:0], res_tog_ff};
    end
    wire rx_evt = tog_s_ff[2] ^ tog_s_ff[1];
    wire [5:0] acc_en = no_host ? 6'h00 :
                        {rfrc_ff[5], rfrc_ff[4] && mac_ctrl[`EP_MC_FDX],
                         rfrc_ff[3:0]};
    wire runt = res_len_ff < `EP_RUNT_LEN;
    wire rx_big = over_max(res_len_ff, max_ff);
    wire rx_rej = runt || res_fl_ff[6] || rx_big ||
                  |(res_fl_ff[5:0] & ~acc_en);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rfs_ff <= 8'h00;
            rx_accept <= 1'b0;
            rx_reject <= 1'b0;
        end else begin
            if (rx_evt) begin
                rfs_ff <= {rx_big, runt || res_fl_ff[6], res_fl_ff[5:0]};
            end
            rx_accept <= rx_evt && !rx_rej;
            rx_reject <= rx_evt && rx_rej;
        end
    end

    byte_t rd_mux_ff;
    assign host_rdata = rd_mux_ff;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) rd_mux_ff <= 8'h00;
        else if (host_rd) rd_mux_ff <= rd_mux;
    end

    // Checks kept beside the logic they guard.
    cs_clears_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(cs_ff) |-> ##[1:IND_MAX] !cs_ff)
        else $error("command status did not clear");
    rd_data_a: assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(cs_ff) && dir_ff && r_idx != 3'h7 |->
            rdata_ff == mac_reg_ff[r_idx])
        else $error("read data not valid at status clear");
    nohost_retry_a: assert property (@(posedge core_clk) disable iff (!rstn)
        tx_done && no_host && |tx_err |=> tx_retry)
        else $error("errored frame not resent without host");
    flush_nc_a: assert property (@(posedge core_clk) disable iff (!rstn)
        tx_done && tx_err[1] && tfrc_ff[9] |=> tx_queue_flush)
        else $error("queue not flushed on no carrier");
    runt_rej_a: assert property (@(posedge core_clk) disable iff (!rstn)
        rx_evt && res_len_ff < 11'd64 |=> rx_reject && !rx_accept)
        else $error("runt frame accepted");
    long_rej_a: assert property (@(posedge core_clk) disable iff (!rstn)
        rx_evt && res_len_ff > max_ff[10:0] && max_ff[15:11] == 5'h0
            |=> rx_reject)
        else $error("oversize frame accepted");
    auto_pause_a: assert property (@(posedge core_clk) disable iff (!rstn)
        auto_flow ##1 auto_flow |-> !pause_req && !jam_req)
        else $error("host flow request under automatic control");
    sfd_path_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        rx_st_ff == RX_DATA |-> $past(rx_st_ff) != RX_IDLE)
        else $error("data state entered without delimiter");
endmodule

// File: test/phy_rx_model.sv
`timescale 1ns/1ps
// Receive half of a PHY: free-running receive clock and nibble frames, or two-bit symbols when rmii is set.
module phy_rx_model (
    output logic link_clk,
    output logic rx_dv,
    output logic rx_er,
    output logic [3:0] rxd,
    output logic col
);
    // Symbol width for the next frames: two-bit symbols when set.
    bit rmii = 1'b0;
    // The clock runs free, as a PHY's does, at a phase unrelated to core.
    initial begin
        link_clk = 1'b0;
        rx_dv = 1'b0;
        rx_er = 1'b0;
        rxd = 4'h0;
        col = 1'b0;
        #3;
        forever #16 link_clk = ~link_clk;
    end
    // Builds preamble, header, payload and CRC and sends low nibble first.
    task automatic send(input int n, input bit bad, input bit clash);
        logic [7:0] f[$];
        logic [7:0] b;
        logic [31:0] crc;
        crc = 32'hffffffff;
        for (int i = 0; i < 8; i++) begin
            f.push_back(i == 7 ? 8'hd5 : 8'h55);
        end
        for (int i = 0; i < n - 4; i++) begin
            b = (i == 12) ? 8'h08 : ((i == 13) ? 8'h00 : i[7:0]);
            f.push_back(b);
            for (int k = 0; k < 8; k++) begin
                crc = (crc >> 1) ^ ((crc[0] ^ b[k]) ? 32'hedb88320 : 32'h0);
            end
        end
        crc = ~crc ^ {31'h0, bad};
        for (int k = 0; k < 4; k++) begin
            f.push_back(crc[8*k +: 8]);
        end
        foreach (f[j]) begin
            for (int h = 0; h < (rmii ? 4 : 2); h++) begin
                @(posedge link_clk);
                rx_dv <= 1'b1;
                rxd <= rmii ? {2'h0, f[j][2*h +: 2]} : f[j][4*h +: 4];
                col <= clash && (j == 20);
            end
        end
        // A released data line shows the inverse, never a stale nibble.
        @(posedge link_clk);
        rx_dv <= 1'b0;
        col <= 1'b0;
        rxd <= ~rxd;
    endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
    import eth_port_pkg::*;
    logic core_clk = 1'b0, rstn = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
    logic [4:0] host_addr = 5'h00;
    byte_t host_wdata = 8'h00, host_rdata;
    logic hw_mode = 1'b0, auto_flow = 1'b0, rps = 1'b0, role = 1'b0;
    logic link_clk, rx_dv, rx_er, col, clk_out, clk_oe_n, tx_done = 1'b0;
    logic [3:0] rxd;
    logic [8:0] tx_err = 9'h000;
    logic [10:0] tx_len = 11'h000;
    logic tx_retry, tx_drop, tx_flush, rx_accept, rx_reject;
    logic pause_done = 1'b0, pause_req, jam_req;
    int n_mismatch = 0, comparisons = 0, n_acc = 0, n_rej = 0;
    int n_dce = 0;
    logic [7:0] v;
    logic [31:0] w;
    logic [9:0] m;

    always #4 core_clk = ~core_clk;

    phy_rx_model u_phy (.link_clk(link_clk), .rx_dv(rx_dv), .rx_er(rx_er),
        .rxd(rxd), .col(col));

    ethernet_port_mac_control u_dut (.core_clk(core_clk), .rstn(rstn),
        .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .hw_mode(hw_mode),
        .auto_flow(auto_flow), .reduced_pin_select(rps),
        .port_role_select(role), .link_clk(link_clk), .rx_dv(rx_dv),
        .rx_er(rx_er), .rxd(rxd), .col(col), .dce_clk_out(clk_out),
        .dce_clk_oe_n(clk_oe_n), .tx_done(tx_done), .tx_err(tx_err),
        .tx_len(tx_len), .tx_retry(tx_retry), .tx_drop(tx_drop),
        .tx_queue_flush(tx_flush), .rx_accept(rx_accept),
        .rx_reject(rx_reject), .pause_done(pause_done),
        .pause_req(pause_req), .jam_req(jam_req));

    // Pulses are counted half a cycle after they land, away from the edge.
    always @(negedge core_clk) begin
        n_acc += rx_accept;
        n_rej += rx_reject;
    end

    // Rising edges of the DCE clock output, counted for the rate check.
    always @(posedge clk_out) n_dce++;

    task automatic chk(input string name, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge core_clk);
        host_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge core_clk);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge core_clk);
        host_rd <= 1'b0;
        #1 d = host_rdata;
    endtask

    // Polls command status under a bound; a new transfer waits for it.
    task automatic wait_cs();
        for (int i = 0; i < 20; i++) begin
            rd(5'h06, v);
            if (v[0] === 1'b0) break;
        end
        chk("command_status", v[0], 0);
    endtask

    task automatic mac_wr(input logic [15:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++) wr(5'(i), d[8*i +: 8]);
        wr(5'h04, a[7:0]);
        wr(5'h05, a[15:8]);
        wr(5'h06, 8'h01);
        wait_cs();
    endtask

    task automatic mac_rd(input logic [15:0] a, output logic [31:0] d);
        wr(5'h07, a[7:0]);
        wr(5'h08, a[15:8]);
        wr(5'h06, 8'h02);
        wait_cs();
        for (int i = 0; i < 4; i++) rd(5'(9 + i), d[8*i +: 8]);
    endtask

    task automatic tx(input logic [8:0] e, input logic [10:0] l,
                      input logic [2:0] exp);
        @(posedge core_clk);
        tx_done <= 1'b1;
        tx_err <= e;
        tx_len <= l;
        @(posedge core_clk);
        tx_done <= 1'b0;
        #1 chk("retry_flush_drop", {tx_retry, tx_flush, tx_drop}, exp);
    endtask

    task automatic rx(input int n, input bit bad, clash, exp);
        int a0, r0;
        a0 = n_acc;
        r0 = n_rej;
        u_phy.send(n, bad, clash);
        repeat (20) @(posedge core_clk);
        chk("rx_accept", n_acc - a0, exp);
        chk("rx_reject", n_rej - r0, !exp);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #600000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(5'h0d, v);
        chk("max_hi", v, 8'h05);
        rd(5'h0e, v);
        chk("max_lo", v, 8'hee);
        mac_wr(16'h0004, 32'hcafe_0123);
        mac_rd(16'h0004, w);
        chk("indirect", w, 32'hcafe_0123);
        mac_rd(16'h0200, w);
        chk("unmapped", w, 0);
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            m = 10'(1 << i);
            wr(5'h0f, m[7:0]);
            wr(5'h10, {6'h0, m[9:8]});
            tx(9'(1 << i), 11'd64, 3'b100);
            tx(9'(1 << ((i + 1) % 9)), 11'd64, 3'b000);
            rd(5'h13, v);
            chk("tx_status_lo", v, i == 7 ? 8'h00 : 8'(1 << ((i + 1) % 9)));
        end
        wr(5'h10, 8'h02);
        tx(9'h002, 11'd64, 3'b010);
        wr(5'h0d, 8'h00);
        wr(5'h0e, 8'h46);
        tx(9'h000, 11'd71, 3'b001);
        tx(9'h000, 11'd70, 3'b000);
        $display("test transmit done");
        rx(64, 0, 0, 1);
        rx(63, 0, 0, 0);
        rx(64, 0, 1, 0);
        rx(64, 1, 0, 0);
        rd(5'h15, v);
        chk("rx_status", v, 8'h04);
        wr(5'h11, 8'h04);
        rx(64, 1, 0, 1);
        rx(71, 0, 0, 0);
        rx(70, 0, 0, 1);
        hw_mode <= 1'b1;
        rx(64, 1, 0, 0);
        wr(5'h10, 8'h00);
        tx(9'h020, 11'd64, 3'b100);
        hw_mode <= 1'b0;
        $display("test receive done");
        mac_wr(16'h001c, 32'h1);
        repeat (3) @(posedge core_clk);
        chk("pause_req", pause_req, 1);
        @(posedge core_clk);
        pause_done <= 1'b1;
        @(posedge core_clk);
        pause_done <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("pause_req", pause_req, 0);
        wr(5'h12, 8'h01);
        repeat (3) @(posedge core_clk);
        chk("jam_req", jam_req, 1);
        auto_flow <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("jam_req", jam_req, 0);
        $display("test flow control done");
        for (int i = 0; i < 4; i++) begin
            rps <= i[0];
            role <= i[1];
            repeat (5) @(posedge core_clk);
            rd(5'h16, v);
            chk("mode", v, 8'(i));
            chk("clk_oe_n", clk_oe_n, i != 2);
        end
        @(posedge link_clk);
        w = n_dce;
        repeat (40) @(posedge link_clk);
        chk("dce_clk_rises", n_dce - w, 4);
        u_phy.rmii = 1'b1;
        rx(64, 0, 0, 1);
        $display("test pins done");
        print_verdict();
    end
endmodule
